// ===== pkg/fbcfg_defines.vh
`ifndef FBCFG_DEFINES_VH
`define FBCFG_DEFINES_VH
// ----------------------------------------
// register word offsets
// ----------------------------------------
`define OFS_CTRL 4'h0
`define OFS_SWADDR 4'h1
`define OFS_STATUS 4'h2
`define OFS_IRQ_STAT 4'h3
`define OFS_IRQ_MASK 4'h4
`define OFS_ERR_SET 4'h5
`define OFS_ERR_CLR 4'h6
`define OFS_ERR_INFO 4'h7
`define OFS_ERR_CLASS 4'h8
`define OFS_ACYC_WR 4'h9
`define OFS_ID 4'hA
// ----------------------------------------
// fields
// ----------------------------------------
`define CTRL_READY_BIT 0
`define ADDR_MIN 7'h01
`define ADDR_MAX 7'h7E
`define ADDR_FACTORY 7'h7E
`define ERR_N 8
`define ERR_CLASS_RST 8'h0F
`define IRQ_FAULT_BIT 0
`define IRQ_NOTICE_BIT 1
`define IRQ_WPREJ_BIT 2
`define IRQ_ACCEPT_BIT 3
`define DEVICE_ID 16'h0A5C // arbitrary value
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 100000000
`define LED_HALF_MS 250
`define LED_HALF_CYC (`CLK_HZ / 1000 * `LED_HALF_MS)
`define SAMPLE_DLY_CYC 16
`endif

// ===== rtl/sw_sync.v
`default_nettype none
module sw_sync #(
  parameter W = 8
) (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // pins
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule // sw_sync
`default_nettype wire

// ===== rtl/err_prio.v
`default_nettype none
`include "fbcfg_defines.vh"
module err_prio (
  // errors
  input wire [`ERR_N-1:0] err_i,
  // selected
  output reg found_o,
  output reg [2:0] idx_o
);
  integer i;
  // lowest index wins: index 0 is highest priority
  always @* begin
    found_o = 1'b0;
    idx_o = 3'h0;
    for (i = `ERR_N - 1; i >= 0; i = i - 1) begin
      if (err_i[i]) begin
        found_o = 1'b1;
        idx_o = i[2:0];
      end
    end
  end
endmodule // err_prio
`default_nettype wire

// ===== rtl/fb_cfg_status.v
// Functional notes
// - every error is exactly one class: fault or notice
// - serious system errors are always faults
// - notice leaves operation running; shows notice marker and system/process tag
// - fault halts operation; shows fault marker and system/process tag
// - write-protect jumper set rejects all acyclic fieldbus writes
// - factory jumper position is unprotected, writes accepted
// - only station addresses 1 to 126 are valid
// - factory default address 126, software addressing
// - mode switch off selects software address, on selects switch bank
// - hardware address is sum of binary weights of closed switches
// - led steady when ready, dark when not, flashing on error
// - only the highest priority active error is shown
`default_nettype none
`include "fbcfg_defines.vh"
module fb_cfg_status (
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // board switches and jumper (pins)
  input wire [6:0] addr_sw_i,
  input wire addr_mode_sw_i,
  input wire wp_jumper_i,
  // error sources
  input wire [`ERR_N-1:0] err_i,
  input wire [`ERR_N-1:0] err_serious_i,
  input wire [`ERR_N-1:0] err_is_proc_i,
  // acyclic fieldbus write request
  input wire acyc_wr_req_i,
  output wire acyc_wr_ack_o,
  output wire acyc_wr_rej_o,
  // status
  output wire [6:0] station_addr_o,
  output wire addr_valid_o,
  output wire halt_o,
  output wire [2:0] err_show_idx_o,
  output wire err_show_fault_o,
  output wire err_show_notice_o,
  output wire err_show_proc_o,
  output wire led_o,
  output wire irq_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [8:0] pins_s;
  sw_sync #(.W(9)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({wp_jumper_i, addr_mode_sw_i, addr_sw_i}),
    .q_o(pins_s)
  );

  // ----------------------------------------
  // strap capture after reset
  // ----------------------------------------
  // wait so both sync stages hold real pin values before latching
  reg [4:0] smp_cnt_r;
  reg sampled_r;
  reg [6:0] hw_addr_r;
  reg mode_hw_r;
  reg wp_r;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp_cnt_r <= 5'h00;
      sampled_r <= 1'b0;
      hw_addr_r <= 7'h00;
      mode_hw_r <= 1'b0;
      wp_r <= 1'b0;
    end else if (!sampled_r) begin
      if (smp_cnt_r == `SAMPLE_DLY_CYC - 1) begin
        sampled_r <= 1'b1;
        hw_addr_r <= pins_s[6:0];
        mode_hw_r <= pins_s[7];
        wp_r <= pins_s[8];
      end else begin
        smp_cnt_r <= smp_cnt_r + 5'h01;
      end
    end
  end
  // changing a switch later needs a reset, as on a powered-down board

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg ready_r;
  reg [6:0] sw_addr_r;
  reg [`ERR_N-1:0] err_sw_r;
  reg [`ERR_N-1:0] class_fault_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_mask_r;
  reg [15:0] acyc_ok_cnt_r;
  reg [15:0] acyc_rej_cnt_r;

  wire wr_en = avs_write_i;
  wire rd_en = avs_read_i;
  reg rd_done_r;
  // one wait state per read; the capture edge is where the read takes effect
  wire rd_cap = rd_en && !rd_done_r;
  wire rd_irq = rd_cap && (avs_address_i == `OFS_IRQ_STAT);

  // ----------------------------------------
  // address selection
  // ----------------------------------------
  // switch settings 0 and 127 fall outside the range and give no address
  wire [6:0] raw_addr = mode_hw_r ? hw_addr_r : sw_addr_r;
  wire addr_ok = (raw_addr >= `ADDR_MIN) && (raw_addr <= `ADDR_MAX);
  assign station_addr_o = addr_ok ? raw_addr : 7'h00;
  assign addr_valid_o = addr_ok && sampled_r;

  // ----------------------------------------
  // error classification
  // ----------------------------------------
  wire [`ERR_N-1:0] err_all = err_i | err_sw_r;
  // serious forces fault, otherwise the class register decides
  wire [`ERR_N-1:0] is_fault = class_fault_r | err_serious_i;
  wire [`ERR_N-1:0] fault_act = err_all & is_fault;
  wire [`ERR_N-1:0] notice_act = err_all & ~is_fault;
  wire any_err = |err_all;
  wire any_fault = |fault_act;
  wire found;
  wire [2:0] sel;
  // lowest set index wins
  err_prio u_prio (
    .err_i(err_all),
    .found_o(found),
    .idx_o(sel)
  );
  // registered so the shown error does not glitch while sources settle
  reg show_valid_r;
  reg [2:0] show_idx_r;
  reg show_fault_r;
  reg show_proc_r;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      show_valid_r <= 1'b0;
      show_idx_r <= 3'h0;
      show_fault_r <= 1'b0;
      show_proc_r <= 1'b0;
    end else begin
      show_valid_r <= found;
      show_idx_r <= sel;
      show_fault_r <= is_fault[sel];
      show_proc_r <= err_is_proc_i[sel];
    end
  end
  assign err_show_idx_o = show_idx_r;
  assign err_show_fault_o = show_valid_r && show_fault_r;
  assign err_show_notice_o = show_valid_r && !show_fault_r;
  assign err_show_proc_o = show_valid_r && show_proc_r;
  // notices never reach halt
  assign halt_o = any_fault;

  // ----------------------------------------
  // acyclic write gate
  // ----------------------------------------
  // jumper state is unknown until sampled, so refuse until then
  wire wp_block = wp_r || !sampled_r;
  assign acyc_wr_ack_o = acyc_wr_req_i && !wp_block;
  assign acyc_wr_rej_o = acyc_wr_req_i && wp_block;

  // ----------------------------------------
  // status led
  // ----------------------------------------
  // free-running blink: the first phase after an error may be short
  reg [24:0] led_cnt_r;
  reg blink_r;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_cnt_r <= 25'h0000000;
      blink_r <= 1'b0;
    end else if (led_cnt_r == `LED_HALF_CYC - 1) begin
      led_cnt_r <= 25'h0000000;
      blink_r <= ~blink_r;
    end else begin
      led_cnt_r <= led_cnt_r + 25'h0000001;
    end
  end
  wire ready = ready_r && sampled_r && addr_ok;
  reg led_r;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_r <= 1'b0;
    end else begin
      led_r <= any_err ? blink_r : ready;
    end
  end
  assign led_o = led_r;

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  reg any_fault_d_r;
  reg any_notice_d_r;
  // fault and notice events are edges, so a standing error raises its bit once
  wire [3:0] irq_ev;
  assign irq_ev[`IRQ_FAULT_BIT] = any_fault && !any_fault_d_r;
  assign irq_ev[`IRQ_NOTICE_BIT] = (|notice_act) && !any_notice_d_r;
  assign irq_ev[`IRQ_WPREJ_BIT] = acyc_wr_rej_o;
  assign irq_ev[`IRQ_ACCEPT_BIT] = acyc_wr_ack_o;
  // set wins over the read clear
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      any_fault_d_r <= 1'b0;
      any_notice_d_r <= 1'b0;
      irq_stat_r <= 4'h0;
    end else begin
      any_fault_d_r <= any_fault;
      any_notice_d_r <= |notice_act;
      irq_stat_r <= (rd_irq ? 4'h0 : irq_stat_r) | irq_ev;
    end
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_r <= 1'b0;
      sw_addr_r <= `ADDR_FACTORY;
      err_sw_r <= {`ERR_N{1'b0}};
      class_fault_r <= `ERR_CLASS_RST;
      irq_mask_r <= 4'h0;
      acyc_ok_cnt_r <= 16'h0000;
      acyc_rej_cnt_r <= 16'h0000;
    end else begin
      // counters wrap; software reads them as a pair
      if (acyc_wr_ack_o) begin
        acyc_ok_cnt_r <= acyc_ok_cnt_r + 16'h0001;
      end
      if (acyc_wr_rej_o) begin
        acyc_rej_cnt_r <= acyc_rej_cnt_r + 16'h0001;
      end
      if (wr_en) begin
        case (avs_address_i)
          `OFS_CTRL: ready_r <= avs_writedata_i[`CTRL_READY_BIT];
          `OFS_SWADDR: begin
            // out-of-range value is ignored, old address kept
            if (avs_writedata_i[6:0] >= `ADDR_MIN && avs_writedata_i[6:0] <= `ADDR_MAX) begin
              sw_addr_r <= avs_writedata_i[6:0];
            end
          end
          `OFS_IRQ_MASK: irq_mask_r <= avs_writedata_i[3:0];
          `OFS_ERR_SET: err_sw_r <= err_sw_r | avs_writedata_i[`ERR_N-1:0];
          `OFS_ERR_CLR: err_sw_r <= err_sw_r & ~avs_writedata_i[`ERR_N-1:0];
          `OFS_ERR_CLASS: class_fault_r <= avs_writedata_i[`ERR_N-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  reg [31:0] rd_word;
  assign avs_waitrequest_o = rd_cap;
  always @* begin
    rd_word = 32'h00000000;
    case (avs_address_i)
      `OFS_CTRL: rd_word = {31'h00000000, ready_r};
      `OFS_SWADDR: rd_word = {25'h0000000, sw_addr_r};
      `OFS_STATUS: rd_word = {16'h0000, hw_addr_r, addr_ok, sampled_r, wp_r, mode_hw_r,
                              any_err, any_fault, ready, 2'h0};
      `OFS_IRQ_STAT: rd_word = {28'h0000000, irq_stat_r};
      `OFS_IRQ_MASK: rd_word = {28'h0000000, irq_mask_r};
      `OFS_ERR_SET: rd_word = {24'h000000, err_all};
      `OFS_ERR_INFO: rd_word = {8'h00, fault_act, 4'h0, show_valid_r, show_fault_r, show_proc_r,
                                1'b0, 5'h00, show_idx_r};
      `OFS_ERR_CLASS: rd_word = {24'h000000, class_fault_r};
      `OFS_ACYC_WR: rd_word = {acyc_rej_cnt_r, acyc_ok_cnt_r};
      `OFS_ID: rd_word = {16'h0000, `DEVICE_ID}; // arbitrary value
      default: rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // captured while waitrequest is high, so the word stands when it drops
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_done_r <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      rd_done_r <= rd_cap;
      if (rd_cap) begin
        avs_readdata_o <= rd_word;
      end
    end
  end
endmodule // fb_cfg_status
`default_nettype wire

// ===== dv/fb_cfg_status_assertions.sv
`default_nettype none
module fb_cfg_status_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic [3:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [7:0] err_i,
  input wire logic [7:0] err_serious_i,
  input wire logic [7:0] err_is_proc_i,
  input wire logic wp_jumper_i,
  input wire logic acyc_wr_req_i,
  input wire logic acyc_wr_ack_o,
  input wire logic acyc_wr_rej_o,
  input wire logic [6:0] station_addr_o,
  input wire logic addr_valid_o,
  input wire logic halt_o,
  input wire logic [2:0] err_show_idx_o,
  input wire logic err_show_fault_o,
  input wire logic err_show_notice_o,
  input wire logic err_show_proc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // shown error lags inputs by one edge, so only judge steady inputs
  sequence s_steady;
    $stable(err_i) && $stable(err_serious_i) && $stable(err_is_proc_i) && err_i != 8'h00 && $past(rst_n_i);
  endsequence
  property p_one_class;
    s_steady |-> err_show_fault_o ^ err_show_notice_o;
  endproperty
  a_one_class: assert property (p_one_class) else $error("shown error not in exactly one class");
  property p_serious;
    (err_i & err_serious_i) != 8'h00 |-> halt_o;
  endproperty
  a_serious: assert property (p_serious) else $error("serious error did not halt");
  property p_proc;
    s_steady |-> err_show_proc_o == err_is_proc_i[err_show_idx_o];
  endproperty
  a_proc: assert property (p_proc) else $error("origin tag wrong");
  property p_fault_halt;
    s_steady |-> !err_show_fault_o || halt_o;
  endproperty
  a_fault_halt: assert property (p_fault_halt) else $error("fault shown without halt");
  property p_prio;
    s_steady |-> err_i[err_show_idx_o] && (err_i & ((8'h01 << err_show_idx_o) - 8'h01)) == 8'h00;
  endproperty
  a_prio: assert property (p_prio) else $error("shown error not highest priority");
  property p_wp;
    acyc_wr_req_i && wp_jumper_i |-> acyc_wr_rej_o && !acyc_wr_ack_o;
  endproperty
  a_wp: assert property (p_wp) else $error("write accepted while protected");
  property p_answer;
    acyc_wr_req_i && !wp_jumper_i && addr_valid_o |-> acyc_wr_ack_o && !acyc_wr_rej_o;
  endproperty
  a_answer: assert property (p_answer) else $error("acyclic write refused while unprotected");
  property p_range;
    addr_valid_o |-> station_addr_o >= 7'h01 && station_addr_o <= 7'h7E;
  endproperty
  a_range: assert property (p_range) else $error("valid address out of range");
  property p_hold;
    $changed(station_addr_o) && $past(addr_valid_o) |-> $past(avs_write_i) && $past(avs_address_i) == 4'h1;
  endproperty
  a_hold: assert property (p_hold) else $error("address moved without a write");
endmodule // fb_cfg_status_checker
bind fb_cfg_status fb_cfg_status_checker u_chk (.ref_clk_i, .rst_n_i, .avs_address_i, .avs_write_i, .err_i,
  .err_serious_i, .err_is_proc_i, .wp_jumper_i, .acyc_wr_req_i, .acyc_wr_ack_o, .acyc_wr_rej_o, .station_addr_o,
  .addr_valid_o, .halt_o, .err_show_idx_o, .err_show_fault_o, .err_show_notice_o, .err_show_proc_o);
`default_nettype wire

// ===== dv/fb_master_model.sv
`default_nettype none
module fb_master_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // bench control
  input wire logic go_i,
  // acyclic write
  output logic req_o,
  input wire logic ack_i,
  input wire logic rej_i,
  // outcome
  output logic ack_seen_o,
  output logic rej_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // single master, single station: no address clash on the segment
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 1'b0;
      ack_seen_o <= 1'b0;
      rej_seen_o <= 1'b0;
    end else begin
      req_o <= go_i;
      if (req_o) begin
        ack_seen_o <= ack_i;
        rej_seen_o <= rej_i;
      end
    end
  end
endmodule // fb_master_model
`default_nettype wire

// ===== dv/fieldbus_addr_wprot_status_test.sv
`default_nettype none
`include "fbcfg_defines.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module fieldbus_addr_wprot_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [6:0] addr_sw_i = 7'h00;
  logic addr_mode_sw_i = 1'b0;
  logic wp_jumper_i = 1'b0;
  logic [7:0] err_i = 8'h00;
  logic [7:0] err_serious_i = 8'h00;
  logic [7:0] err_is_proc_i = 8'h00;
  logic go = 1'b0;
  wire [31:0] avs_readdata_o;
  wire [6:0] station_addr_o;
  wire [2:0] err_show_idx_o;
  wire avs_waitrequest_o, acyc_wr_req_i, acyc_wr_ack_o, acyc_wr_rej_o, addr_valid_o, halt_o, led_o, irq_o;
  wire err_show_fault_o, err_show_notice_o, err_show_proc_o, ack_seen, rej_seen;
  wire [6:0] show = {halt_o, err_show_fault_o, err_show_notice_o, err_show_proc_o, err_show_idx_o};
  int err_total = 0;
  int checked = 0;
  fb_cfg_status u_dut (.ref_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .addr_sw_i, .addr_mode_sw_i, .wp_jumper_i, .err_i, .err_serious_i,
    .err_is_proc_i, .acyc_wr_req_i, .acyc_wr_ack_o, .acyc_wr_rej_o, .station_addr_o, .addr_valid_o, .halt_o,
    .err_show_idx_o, .err_show_fault_o, .err_show_notice_o, .err_show_proc_o, .led_o, .irq_o);
  fb_master_model u_master (.ref_clk_i, .rst_n_i, .go_i(go), .req_o(acyc_wr_req_i), .ack_i(acyc_wr_ack_o),
    .rej_i(acyc_wr_rej_o), .ack_seen_o(ack_seen), .rej_seen_o(rej_seen));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 100) begin
      n++;
      @(posedge ref_clk_i);
    end
    if (n >= 100) begin
      err_total++;
      conclude();
    end
    q = avs_readdata_o;
    // released here; the next call waits an edge, so no double drive
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic do_reset(input logic m, input logic [6:0] s, input logic w);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    addr_mode_sw_i <= m;
    addr_sw_i <= s;
    wp_jumper_i <= w;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // strap sample lands 16 edges after release; the synchroniser is filled well before that
    repeat (20) @(posedge ref_clk_i);
  endtask
  task automatic acyc(input logic e_ack);
    @(posedge ref_clk_i);
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK("ack", e_ack, ack_seen)
    `CHK("rej", !e_ack, rej_seen)
  endtask
  task automatic wait_show;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task automatic t_defaults;
    logic [31:0] q;
    do_reset(1'b0, 7'h31, 1'b0);
    @(negedge ref_clk_i);
    `CHK("station", 7'h7E, station_addr_o)
    bus(1'b0, `OFS_SWADDR, 32'h0, q);
    `CHK("swaddr", 32'h7E, q)
    bus(1'b0, `OFS_ERR_CLASS, 32'h0, q);
    `CHK("class", 32'h0F, q)
    bus(1'b0, 4'hF, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    acyc(1'b1);
  endtask
  task automatic t_swaddr;
    logic [31:0] q;
    logic [6:0] wv [4] = '{7'h05, 7'h00, 7'h7F, 7'h7E};
    logic [6:0] ev [4] = '{7'h05, 7'h05, 7'h05, 7'h7E};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `OFS_SWADDR, {25'h0, wv[i]}, q);
      @(negedge ref_clk_i);
      `CHK("station", ev[i], station_addr_o)
    end
  endtask
  task automatic t_hw;
    logic [31:0] q;
    do_reset(1'b1, 7'h31, 1'b1);
    @(negedge ref_clk_i);
    `CHK("station", 7'h31, station_addr_o)
    `CHK("valid", 1'b1, addr_valid_o)
    bus(1'b0, `OFS_STATUS, 32'h0, q);
    `CHK("status", 32'h000063E0, q)
    acyc(1'b0);
    @(posedge ref_clk_i);
    addr_sw_i <= 7'h05;
    wait_show();
    `CHK("held", 7'h31, station_addr_o)
  endtask
  task automatic t_led;
    logic [31:0] q;
    `CHK("led", 1'b0, led_o)
    bus(1'b1, `OFS_CTRL, 32'h1, q);
    wait_show();
    `CHK("led", 1'b1, led_o)
  endtask
  task automatic t_err;
    logic [31:0] q;
    bus(1'b1, `OFS_IRQ_MASK, 32'h1, q);
    @(posedge ref_clk_i);
    err_is_proc_i <= 8'h08;
    err_i <= 8'h60;
    wait_show();
    `CHK("show", 7'h15, show)
    `CHK("led", 1'b0, led_o)
    @(posedge ref_clk_i);
    err_serious_i <= 8'h40;
    err_i <= 8'h40;
    wait_show();
    `CHK("show", 7'h66, show)
    `CHK("irq", 1'b1, irq_o)
    bus(1'b0, `OFS_IRQ_STAT, 32'h0, q);
    `CHK("stat", 1'b1, q[0])
    wait_show();
    `CHK("irq", 1'b0, irq_o)
    @(posedge ref_clk_i);
    err_i <= 8'h48;
    wait_show();
    `CHK("show", 7'h6B, show)
    bus(1'b1, `OFS_IRQ_MASK, 32'h0, q);
    @(posedge ref_clk_i);
    err_i <= 8'h20;
    wait_show();
    `CHK("show", 7'h15, show)
    `CHK("irq", 1'b0, irq_o)
    bus(1'b0, `OFS_IRQ_STAT, 32'h0, q);
    `CHK("stat", 1'b1, q[1])
    bus(1'b1, `OFS_ERR_SET, 32'h80, q);
    bus(1'b0, `OFS_ERR_SET, 32'h0, q);
    `CHK("errs", 32'hA0, q)
    bus(1'b1, `OFS_ERR_CLR, 32'h80, q);
    bus(1'b1, `OFS_ERR_CLASS, 32'h20, q);
    wait_show();
    `CHK("show", 7'h65, show)
    bus(1'b0, `OFS_ERR_SET, 32'h0, q);
    `CHK("errs", 32'h20, q)
    bus(1'b0, `OFS_ACYC_WR, 32'h0, q);
    `CHK("acyc", 32'h00010000, q)
  endtask
  initial begin
    t_defaults();
    t_swaddr();
    t_hw();
    t_led();
    t_err();
    conclude();
  end
endmodule // fieldbus_addr_wprot_status_test
`default_nettype wire
